// File: rtl/nsc_network_setup_config.sv
// setup register, nack diagnostics, rate and arbitration clocks, bus slave
//
// Local design decisions: the Avalon-MM register port and the register addresses.
`timescale 1ns/1ps
module nsc_network_setup_config #(
	parameter int MEM_ACCESS_TICKS = 2
)(
	input  wire logic                ref_clk_in,
	input  wire logic                srst_in,
	input  wire logic                ce_in,
	input  wire nsc_pkg::nsc_av_req_t av_req_in,
	output logic                     av_waitrequest_out,
	output logic [31:0]              av_readdata_out,
	output logic                     irq_out,
	input  wire logic                nack_detect_in,
	input  wire logic                enquiry_ok_in,
	input  wire nsc_pkg::nsc_packet_t packet_in,
	input  wire logic                pulse_level_in,
	input  wire logic                mem_req_in,
	output logic                     packet_accept_out,
	output logic                     ack_send_out,
	output logic                     token_pass_enable_out,
	output logic                     listen_only_out,
	output logic                     excessive_refusal_flag_out,
	output logic                     line_pulse_out,
	output logic                     line_pulse_oe_out,
	output logic                     rate_tick_out,
	output logic                     arb_tick_out,
	output logic                     mem_ack_out
);
	logic [7:0]                 setup_reg;
	nsc_pkg::nsc_setup_t        setup;
	logic [7:0]                 node_id;
	logic                       tx_enable;
	logic [nsc_pkg::IRQ_W-1:0]  irq_status;
	logic [nsc_pkg::IRQ_W-1:0]  irq_enable;
	logic [nsc_pkg::IRQ_W-1:0]  irq_event;
	logic [7:0]                 nack_count;
	logic [7:0]                 nack_limit;
	logic                       excessive_refusal_flag_event;
	logic                       diag_clear;
	logic                       accept_now;
	logic [7:0]                 rate_count;
	logic [7:0]                 rate_div;
	logic                       arb_phase;
	logic                       arb_tick;
	logic [7:0]                 mem_ticks;
	logic                       mem_busy;
	logic                       mem_done;
	logic                       wr_ok;
	logic                       rd_ok;
	logic [31:0]                next_readdata;

	function automatic logic [7:0] rate_divisor(input logic [2:0] code);
		logic [2:0] c;
		c = (code > nsc_pkg::PRESCALE_MAX) ? nsc_pkg::PRESCALE_MAX : code;
		rate_divisor = nsc_pkg::RATE_DIV_BASE << c;
	endfunction

	function automatic logic hit(input logic [nsc_pkg::ADDR_W-1:0] off);
		hit = (av_req_in.address == off);
	endfunction

	assign setup = nsc_pkg::nsc_setup_t'(setup_reg);

	// bus slave: one wait cycle, then the answer at the low-waitrequest edge
	assign wr_ok = av_req_in.write && !av_waitrequest_out
		&& av_req_in.byteenable[0];
	// read data latched in the wait cycle, so it stands while low
	assign rd_ok = av_req_in.read && av_waitrequest_out;

	always_ff @(posedge ref_clk_in)
	begin
		if (srst_in)
			av_waitrequest_out <= 1'b1;
		else if (ce_in)
		begin
			// low for one cycle only, so a held request is not taken twice
			if ((av_req_in.read || av_req_in.write) && av_waitrequest_out)
				av_waitrequest_out <= 1'b0;
			else
				av_waitrequest_out <= 1'b1;
		end
	end

	always_comb
	begin
		next_readdata = 32'h0000_0000;
		if (hit(nsc_pkg::OFF_SETUP))
			next_readdata[7:0] = setup_reg;
		else if (hit(nsc_pkg::OFF_IRQ_STATUS))
			next_readdata[nsc_pkg::IRQ_W-1:0] = irq_status;
		else if (hit(nsc_pkg::OFF_IRQ_ENABLE))
			next_readdata[nsc_pkg::IRQ_W-1:0] = irq_enable;
		else if (hit(nsc_pkg::OFF_DIAG))
		begin
			next_readdata[0] = excessive_refusal_flag_out;
			next_readdata[15:8] = nack_count;
		end
		else if (hit(nsc_pkg::OFF_CONTROL))
			next_readdata[nsc_pkg::CTRL_TX_ENABLE] = tx_enable;
		else if (hit(nsc_pkg::OFF_NODE_ID))
			next_readdata[7:0] = node_id;
	end

	always_ff @(posedge ref_clk_in)
	begin
		if (srst_in)
			av_readdata_out <= 32'h0000_0000;
		else if (ce_in && rd_ok)
			av_readdata_out <= next_readdata;
	end

	// reserved bit is masked so it always reads back zero
	always_ff @(posedge ref_clk_in)
	begin
		if (srst_in)
			setup_reg <= nsc_pkg::SETUP_RESET;
		else if (ce_in && wr_ok && hit(nsc_pkg::OFF_SETUP))
			setup_reg <= av_req_in.writedata[7:0] & nsc_pkg::SETUP_WMASK;
	end

	always_ff @(posedge ref_clk_in)
	begin
		if (srst_in)
			node_id <= nsc_pkg::NODE_ID_RESET;
		else if (ce_in && wr_ok && hit(nsc_pkg::OFF_NODE_ID))
			// node id feeds both the receive filter and the ack compare
			node_id <= av_req_in.writedata[7:0];
	end

	always_ff @(posedge ref_clk_in)
	begin
		if (srst_in)
			tx_enable <= nsc_pkg::CTRL_TX_RESET;
		else if (ce_in && wr_ok && hit(nsc_pkg::OFF_CONTROL))
			// comes up enabled; clearing it with receive_every_packet set gives the monitor mode
			tx_enable <= av_req_in.writedata[nsc_pkg::CTRL_TX_ENABLE];
	end

	// strobe not gated here; every user sits under ce_in
	assign diag_clear = wr_ok && hit(nsc_pkg::OFF_CONTROL)
		&& av_req_in.writedata[nsc_pkg::DIAG_CLEAR];

	always_ff @(posedge ref_clk_in)
	begin
		if (srst_in)
			irq_enable <= '0;
		else if (ce_in && wr_ok && hit(nsc_pkg::OFF_IRQ_ENABLE))
			irq_enable <= av_req_in.writedata[nsc_pkg::IRQ_W-1:0];
	end

	// set beats clear so an event in the clearing cycle survives
	always_comb
	begin
		irq_event = '0;
		irq_event[nsc_pkg::IRQ_EXCESSIVE_REFUSAL_FLAG] = excessive_refusal_flag_event;
		irq_event[nsc_pkg::IRQ_ACCEPT] = accept_now;
		irq_event[nsc_pkg::IRQ_MEMDONE] = mem_done;
	end

	always_ff @(posedge ref_clk_in)
	begin
		if (srst_in)
			irq_status <= '0;
		else if (ce_in)
		begin
			if (wr_ok && hit(nsc_pkg::OFF_IRQ_CLEAR))
				irq_status <= (irq_status
					& ~av_req_in.writedata[nsc_pkg::IRQ_W-1:0]) | irq_event;
			else
				irq_status <= irq_status | irq_event;
		end
	end

	always_ff @(posedge ref_clk_in)
	begin
		if (srst_in)
			irq_out <= 1'b0;
		else if (ce_in)
			// one cycle behind status, but glitch free at the pin
			irq_out <= |(irq_status & irq_enable);
	end

	// nack counting; limit follows the threshold bit live
	assign nack_limit = setup.short_nack_threshold
		? nsc_pkg::NACK_SHORT
		: nsc_pkg::NACK_LONG;
	assign excessive_refusal_flag_event = nack_detect_in && !excessive_refusal_flag_out
		&& (nack_count + 8'h01 >= nack_limit);

	always_ff @(posedge ref_clk_in)
	begin
		if (srst_in)
			nack_count <= 8'h00;
		else if (ce_in)
		begin
			// saturating at FF; below FF a nack beats a clear in the same cycle
			if (nack_detect_in && nack_count != 8'hFF)
				nack_count <= nack_count + 8'h01;
			else if (enquiry_ok_in || diag_clear)
				nack_count <= 8'h00;
		end
	end

	always_ff @(posedge ref_clk_in)
	begin
		if (srst_in)
			excessive_refusal_flag_out <= 1'b0;
		else if (ce_in)
		begin
			if (excessive_refusal_flag_event)
				excessive_refusal_flag_out <= 1'b1;
			else if (diag_clear)
				excessive_refusal_flag_out <= 1'b0;
		end
	end

	// receive filter
	assign accept_now = packet_in.valid
		&& (setup.receive_every_packet || packet_in.dest == node_id);

	always_ff @(posedge ref_clk_in)
	begin
		if (srst_in)
			packet_accept_out <= 1'b0;
		else if (ce_in)
			packet_accept_out <= accept_now;
	end

	// monitor traffic is never acknowledged; listen-only sends nothing
	always_ff @(posedge ref_clk_in)
	begin
		if (srst_in)
			ack_send_out <= 1'b0;
		else if (ce_in)
			ack_send_out <= packet_in.valid && tx_enable
				&& packet_in.dest == node_id;
	end

	always_ff @(posedge ref_clk_in)
	begin
		if (srst_in)
		begin
			token_pass_enable_out <= 1'b0;
			listen_only_out <= 1'b0;
		end
		else if (ce_in)
		begin
			token_pass_enable_out <= tx_enable;
			listen_only_out <= setup.receive_every_packet && !tx_enable;
		end
	end

	// pulse driver: open drain only ever drives the low level
	always_ff @(posedge ref_clk_in)
	begin
		if (srst_in)
		begin
			line_pulse_out <= 1'b0;
			line_pulse_oe_out <= 1'b0;
		end
		else if (ce_in)
		begin
			if (setup.pulse_push_pull)
			begin
				line_pulse_out <= pulse_level_in;
				line_pulse_oe_out <= 1'b1;
			end
			else
			begin
				line_pulse_out <= 1'b0;
				line_pulse_oe_out <= !pulse_level_in;
			end
		end
	end

	// rate prescaler; codes above 100 clamp to the slowest legal divisor
	assign rate_div = rate_divisor(setup.rate_prescaler_field);

	always_ff @(posedge ref_clk_in)
	begin
		if (srst_in)
		begin
			rate_count <= 8'h00;
			rate_tick_out <= 1'b0;
		end
		else if (ce_in)
		begin
			// a count past a shorter divisor ticks at once, no wrap
			if (rate_count + 8'h01 >= rate_div)
			begin
				rate_count <= 8'h00;
				rate_tick_out <= 1'b1;
			end
			else
			begin
				rate_count <= rate_count + 8'h01;
				rate_tick_out <= 1'b0;
			end
		end
	end

	// arbitration clock enable, every cycle or every second one
	assign arb_tick = !setup.halved_arbitration || arb_phase;

	always_ff @(posedge ref_clk_in)
	begin
		if (srst_in)
		begin
			arb_phase <= 1'b0;
			arb_tick_out <= 1'b0;
		end
		else if (ce_in)
		begin
			// phase runs at full rate too, so switching never stalls
			arb_phase <= !arb_phase;
			arb_tick_out <= arb_tick;
		end
	end

	// host memory access counts arbitration ticks, so it stretches too
	assign mem_done = mem_busy && arb_tick
		&& (mem_ticks + 8'h01 >= 8'(MEM_ACCESS_TICKS));

	always_ff @(posedge ref_clk_in)
	begin
		if (srst_in)
		begin
			mem_busy <= 1'b0;
			mem_ticks <= 8'h00;
			mem_ack_out <= 1'b0;
		end
		else if (ce_in)
		begin
			mem_ack_out <= mem_done;
			if (mem_done)
			begin
				mem_busy <= 1'b0;
				mem_ticks <= 8'h00;
			end
			else if (mem_busy && arb_tick)
				mem_ticks <= mem_ticks + 8'h01;
			// ack guard stops a still held request restarting at once
			else if (mem_req_in && !mem_busy && !mem_ack_out)
				mem_busy <= 1'b1;
		end
	end
endmodule

// File: rtl/nsc_pkg.sv
// constants, types and register map of the network setup block
// Notes on behaviour
// - setup bit 7 picks the pulse driver, 1 push/pull, 0 open drain, reset 0.
// - with setup bit 6 set the excessive refusal flag sets after 4 NACKs.
// - with setup bit 6 clear the flag sets only after 128 NACKs, the default.
// - setup bit 4 makes the node accept every valid packet, reset 0.
// - an acknowledgement goes out only when the destination equals our node id.
// - receive-all with the transmitter disabled gives a listen-only monitor.
// - setup bits 3..1 pick divisor 8, 16, 32, 64 or 128 for the data rate.
// - the prescaler field resets to 000, the fastest rate.
// - setup bit 0 halves the memory arbitration clock.
// - halved arbitration lengthens host memory access cycles to match.
package nsc_pkg;
	localparam int ADDR_W = 5;
	localparam logic [ADDR_W-1:0] OFF_SETUP = 5'h00;
	localparam logic [ADDR_W-1:0] OFF_IRQ_STATUS = 5'h04;
	localparam logic [ADDR_W-1:0] OFF_IRQ_CLEAR = 5'h08;
	localparam logic [ADDR_W-1:0] OFF_IRQ_ENABLE = 5'h0C;
	localparam logic [ADDR_W-1:0] OFF_DIAG = 5'h10;
	localparam logic [ADDR_W-1:0] OFF_CONTROL = 5'h14;
	localparam logic [ADDR_W-1:0] OFF_NODE_ID = 5'h18;
	localparam logic [7:0] SETUP_RESET = 8'h00;
	localparam logic [7:0] SETUP_WMASK = 8'hDF;
	localparam logic [7:0] NODE_ID_RESET = 8'h00;
	localparam logic [7:0] NACK_SHORT = 8'h04;
	localparam logic [7:0] NACK_LONG = 8'h80;
	localparam logic [2:0] PRESCALE_MAX = 3'h4;
	localparam logic [7:0] RATE_DIV_BASE = 8'h08;
	localparam int IRQ_W = 3;
	localparam int IRQ_EXCESSIVE_REFUSAL_FLAG = 0;
	localparam int IRQ_ACCEPT = 1;
	localparam int IRQ_MEMDONE = 2;
	localparam int CTRL_TX_ENABLE = 0;
	localparam int DIAG_CLEAR = 1;
	localparam logic CTRL_TX_RESET = 1'b1;
	typedef struct packed {
		logic       pulse_push_pull;
		logic       short_nack_threshold;
		logic       reserved;
		logic       receive_every_packet;
		logic [2:0] rate_prescaler_field;
		logic       halved_arbitration;
	} nsc_setup_t;
	typedef struct packed {
		logic       valid;
		logic [7:0] dest;
	} nsc_packet_t;
	typedef struct packed {
		logic       read;
		logic       write;
		logic [ADDR_W-1:0] address;
		logic [3:0] byteenable;
		logic [31:0] writedata;
	} nsc_av_req_t;
endpackage

// File: test/nsc_monitor.sv
// assertion checker for the network setup block ports
`timescale 1ns/1ps
module nsc_monitor (
	input wire logic                 ref_clk_in,
	input wire logic                 srst_in,
	input wire logic                 ce_in,
	input wire nsc_pkg::nsc_av_req_t av_req_in,
	input wire logic                 av_waitrequest_out,
	input wire nsc_pkg::nsc_packet_t packet_in,
	input wire logic                 nack_detect_in,
	input wire logic                 mem_req_in,
	input wire logic                 packet_accept_out,
	input wire logic                 ack_send_out,
	input wire logic                 excessive_refusal_flag_out,
	input wire logic                 rate_tick_out,
	input wire logic                 arb_tick_out,
	input wire logic                 mem_ack_out
);
	default clocking cb @(posedge ref_clk_in);
	endclocking
	default disable iff (srst_in || !ce_in);
	sequence mem_start;
		$rose(mem_req_in);
	endsequence
	sequence mem_wait;
		!mem_ack_out ##1 !mem_ack_out ##[1:20] mem_ack_out;
	endsequence
	wait_one_a: assert property (!av_waitrequest_out |=> av_waitrequest_out)
		else $error("waitrequest low for more than one cycle");
	wait_cause_a: assert property ((av_req_in.read || av_req_in.write)
		&& av_waitrequest_out |=> !av_waitrequest_out)
		else $error("request not answered after one wait cycle");
	accept_cause_a: assert property (packet_accept_out |->
		$past(packet_in.valid)) else $error("accept without packet");
	ack_own_a: assert property (ack_send_out |-> packet_accept_out)
		else $error("ack without accepted packet");
	rate_gap_a: assert property (rate_tick_out |=>
		!rate_tick_out [*7]) else $error("rate ticks closer than 8");
	arb_gap_a: assert property (!arb_tick_out |=> arb_tick_out)
		else $error("arbitration tick missing twice");
	flag_cause_a: assert property ($rose(excessive_refusal_flag_out)
		|-> $past(nack_detect_in)) else $error("flag set without nack");
	mem_cycle_a: assert property (mem_start |-> mem_wait)
		else $error("memory ack too early or missing");
endmodule

bind nsc_network_setup_config nsc_monitor u_mon (.ref_clk_in, .srst_in, .ce_in,
	.av_req_in, .av_waitrequest_out, .packet_in, .nack_detect_in,
	.mem_req_in, .packet_accept_out, .ack_send_out,
	.excessive_refusal_flag_out, .rate_tick_out, .arb_tick_out,
	.mem_ack_out);

// File: test/tb_top.sv
// self-checking bench for the network setup block
`timescale 1ns/1ps
module tb_top;
	logic                 ref_clk_in, srst_in, ce_in, nack_detect_in;
	logic                 enquiry_ok_in, pulse_level_in, mem_req_in;
	nsc_pkg::nsc_av_req_t av_req_in;
	nsc_pkg::nsc_packet_t packet_in;
	logic [31:0]          av_readdata_out;
	logic [31:0]          rd;
	logic                 av_waitrequest_out, irq_out, packet_accept_out;
	logic                 ack_send_out, token_pass_enable_out;
	logic                 listen_only_out, excessive_refusal_flag_out;
	logic                 line_pulse_out, line_pulse_oe_out, rate_tick_out;
	logic                 arb_tick_out, mem_ack_out;
	int                   n_errors, checks, f, g, h;
	nsc_network_setup_config #(.MEM_ACCESS_TICKS(2)) dut (.ref_clk_in,
		.srst_in, .ce_in, .av_req_in, .av_waitrequest_out,
		.av_readdata_out, .irq_out, .nack_detect_in, .enquiry_ok_in,
		.packet_in, .pulse_level_in, .mem_req_in, .packet_accept_out,
		.ack_send_out, .token_pass_enable_out, .listen_only_out,
		.excessive_refusal_flag_out, .line_pulse_out, .line_pulse_oe_out,
		.rate_tick_out, .arb_tick_out, .mem_ack_out);
	task complete_run;
		$display("errors %0d checks %0d", n_errors, checks);
		if (n_errors == 0 && checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	task chk(input string s, input logic [31:0] e, input logic [31:0] v);
		checks++;
		if (v !== e)
		begin
			n_errors++;
			$display("CHECK FAILED %s expected %h seen %h", s, e, v);
		end
	endtask
	// no limit of its own, the watchdog covers a stuck slave
	task bus(input logic w, input logic [4:0] a, input logic [7:0] d);
		@(posedge ref_clk_in);
		av_req_in.read <= !w;
		av_req_in.write <= w;
		av_req_in.address <= a;
		av_req_in.writedata <= {24'h00_0000, d};
		do
			@(posedge ref_clk_in);
		while (av_waitrequest_out !== 1'b0);
		rd = av_readdata_out;
		av_req_in.read <= 1'b0;
		av_req_in.write <= 1'b0;
	endtask
	task wr(input logic [4:0] a, input logic [7:0] d);
		bus(1'b1, a, d);
	endtask
	task rdc(input string s, input logic [4:0] a, input logic [31:0] e);
		bus(1'b0, a, 8'h00);
		chk(s, e, rd);
	endtask
	task nack(input int n);
		@(posedge ref_clk_in);
		nack_detect_in <= 1'b1;
		repeat (n) @(posedge ref_clk_in);
		nack_detect_in <= 1'b0;
		#1;
	endtask
	task pkt(input logic [7:0] dst, input logic [1:0] e);
		@(posedge ref_clk_in);
		packet_in <= {1'b1, dst};
		@(posedge ref_clk_in);
		packet_in.valid <= 1'b0;
		#1;
		chk("accept_ack", e, {packet_accept_out, ack_send_out});
	endtask
	// third interval only, the first may still run on the old divisor
	task gap(input logic arb, output int len);
		repeat (3)
		begin
			len = 0;
			do
			begin
				@(posedge ref_clk_in);
				len++;
			end
			while ((arb ? arb_tick_out : rate_tick_out) !== 1'b1 && len < 300);
		end
	endtask
	// long idle after release; the request drops at the ack and never restarts
	task mem(output int n);
		@(posedge ref_clk_in);
		mem_req_in <= 1'b1;
		n = 0;
		do
		begin
			@(posedge ref_clk_in);
			n++;
		end
		while (mem_ack_out !== 1'b1 && n < 50);
		mem_req_in <= 1'b0;
		repeat (20) @(posedge ref_clk_in);
	endtask
	initial
	begin
		ref_clk_in = 1'b0;
		forever #5 ref_clk_in = ~ref_clk_in;
	end
	// about 1100 cycles of tests, some eighteen times that as margin
	initial
	begin
		#200000;
		n_errors++;
		complete_run;
	end
	initial
	begin
		n_errors = 0;
		checks = 0;
		{srst_in, ce_in, nack_detect_in, enquiry_ok_in} = 4'h0;
		{srst_in, ce_in} = 2'h3;
		{pulse_level_in, mem_req_in} = 2'h0;
		av_req_in = '0;
		av_req_in.byteenable = 4'hF;
		packet_in = '0;
		repeat (3) @(posedge ref_clk_in);
		srst_in <= 1'b0;
		rdc("setup_rst", nsc_pkg::OFF_SETUP, 32'h0000_0000);
		rdc("ctrl_rst", nsc_pkg::OFF_CONTROL, 32'h0000_0001);
		wr(5'h1C, 8'hFF);
		rdc("unmapped", 5'h1C, 32'h0000_0000);
		wr(nsc_pkg::OFF_SETUP, 8'hD9);
		rdc("setup_rw", nsc_pkg::OFF_SETUP, 32'h0000_00D9);
		for (f = 0; f < 4; f++)
		begin
			wr(nsc_pkg::OFF_SETUP, {f[1], 7'h00});
			pulse_level_in <= f[0];
			repeat (2) @(posedge ref_clk_in);
			#1;
			chk("pulse", f[1] ? {f[0], 1'b1} : {1'b0, !f[0]},
				{line_pulse_out, line_pulse_oe_out});
		end
		wr(nsc_pkg::OFF_IRQ_ENABLE, 8'h01);
		wr(nsc_pkg::OFF_SETUP, 8'h40);
		nack(3);
		chk("flag_3", 0, excessive_refusal_flag_out);
		nack(1);
		chk("flag_4", 1, excessive_refusal_flag_out);
		@(posedge ref_clk_in);
		#1;
		chk("irq_on", 1, irq_out);
		rdc("irq_stat", nsc_pkg::OFF_IRQ_STATUS, 32'h0000_0001);
		wr(nsc_pkg::OFF_IRQ_CLEAR, 8'h01);
		rdc("irq_clr", nsc_pkg::OFF_IRQ_STATUS, 32'h0000_0000);
		chk("irq_off", 0, irq_out);
		wr(nsc_pkg::OFF_IRQ_ENABLE, 8'h00);
		wr(nsc_pkg::OFF_CONTROL, 8'h03);
		wr(nsc_pkg::OFF_SETUP, 8'h00);
		nack(127);
		chk("flag_127", 0, excessive_refusal_flag_out);
		nack(1);
		chk("flag_128", 1, excessive_refusal_flag_out);
		rdc("diag", nsc_pkg::OFF_DIAG, 32'h0000_8001);
		rdc("irq_stat2", nsc_pkg::OFF_IRQ_STATUS, 32'h0000_0001);
		chk("irq_mask", 0, irq_out);
		wr(nsc_pkg::OFF_IRQ_CLEAR, 8'h01);
		wr(nsc_pkg::OFF_NODE_ID, 8'h05);
		av_req_in.byteenable <= 4'hE;
		wr(nsc_pkg::OFF_NODE_ID, 8'h33);
		av_req_in.byteenable <= 4'hF;
		rdc("be_off", nsc_pkg::OFF_NODE_ID, 32'h0000_0005);
		pkt(8'h09, 2'b00);
		pkt(8'h05, 2'b11);
		wr(nsc_pkg::OFF_SETUP, 8'h10);
		pkt(8'h09, 2'b10);
		pkt(8'h05, 2'b11);
		wr(nsc_pkg::OFF_CONTROL, 8'h00);
		@(posedge ref_clk_in);
		#1;
		chk("listen", 2'b10, {listen_only_out, token_pass_enable_out});
		pkt(8'h05, 2'b10);
		for (f = 0; f < 5; f++)
		begin
			wr(nsc_pkg::OFF_SETUP, {4'h0, f[2:0], 1'b0});
			gap(1'b0, g);
			chk("rate_div", 8 << f, g);
		end
		gap(1'b1, g);
		chk("arb_full", 1, g);
		mem(f);
		wr(nsc_pkg::OFF_SETUP, 8'h01);
		gap(1'b1, g);
		chk("arb_half", 2, g);
		mem(h);
		chk("mem_slow", 1, h > f);
		rdc("irq_all", nsc_pkg::OFF_IRQ_STATUS, 32'h0000_0006);
		wr(nsc_pkg::OFF_CONTROL, 8'h03);
		nack(2);
		rdc("diag_cnt", nsc_pkg::OFF_DIAG, 32'h0000_0200);
		@(posedge ref_clk_in);
		enquiry_ok_in <= 1'b1;
		@(posedge ref_clk_in);
		enquiry_ok_in <= 1'b0;
		rdc("enq_clr", nsc_pkg::OFF_DIAG, 32'h0000_0000);
		// frozen cycles must not count the nacks seen meanwhile
		@(posedge ref_clk_in);
		ce_in <= 1'b0;
		nack_detect_in <= 1'b1;
		repeat (3) @(posedge ref_clk_in);
		ce_in <= 1'b1;
		nack_detect_in <= 1'b0;
		rdc("ce_hold", nsc_pkg::OFF_DIAG, 32'h0000_0000);
		complete_run;
	end
endmodule
